// File: logic/hibernation_wake_timer.sv
// Hibernation wake timer: 16-bit down counter with Wishbone registers
//
// Overview of operation
// - Sixteen-bit counter decrements once for each prescaled tick.
// - Fine tick 30.5 us, coarse tick 0.125 s resolutions.
// - Non-zero reload write loads counter and restarts counting.
// - Reaching zero raises a wake-up interrupt toward the controller.
// - Wake event output only while enabled and decremented to zero.
// - Active-low reset returns all registers and control to defaults.
// - Prescaler on the timer clock sets time per counter step.
// - Counting depends only on the timer clock, not other oscillators.
// - Sleep enable inputs are ignored and never alter counting.
// - Bus clock requested only during register accesses.
// - Zero reload write disables counter and stops wake events.
// - Resolution bit one selects coarse, zero selects fine tick.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module hibernation_wake_timer
	import wake_timer_pkg::*;
#(
	parameter int FINE_CYC = FINE_TICK_CYC,
	parameter int COARSE_CYC = COARSE_TICK_CYC
) (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Power controller
	input wire logic sleep_en_i,
	output logic bus_clk_req_o,
	// Events
	output logic hibernation_wake_event_o,
	output logic irq_o
);
	import wake_timer_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] reload;
		logic running;
		logic coarse;
		logic [PRE_W-1:0] pre;
		logic wake;
		logic stat;
		logic mask;
		logic ack;
		logic [31:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic acc;
	logic wr;
	logic tick;
	logic [PRE_W-1:0] pre_lim;
	logic wr_reload;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic rd_acc;

	assign acc = wb_cyc_i && wb_stb_i && !st_r.ack;
	assign wr = acc && wb_we_i;
	// Resolution select picks the prescaler terminal count
	assign pre_lim = st_r.coarse ? PRE_W'(COARSE_CYC - 1) : PRE_W'(FINE_CYC - 1);
	// Compare is >= so a coarse-to-fine switch mid-count cannot overrun
	assign tick = (st_r.pre >= pre_lim);

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	// Used by the checks; the next-state logic decodes the same way
	assign wr_reload = wr && wb_adr_i == OFF_RELOAD && wb_sel_i[1:0] != 2'b00;
	assign wr_ctrl = wr && wb_adr_i == OFF_CTRL && wb_sel_i[0];
	assign wr_stat = wr && wb_adr_i == OFF_IRQ_STAT && wb_sel_i[0];
	assign wr_mask = wr && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0];
	assign rd_acc = acc && !wb_we_i;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = acc;
		st_nxt.wake = 1'b0;
		// Prescaler free-runs only while counting, so a restart is phase clean
		if (st_r.running) begin
			st_nxt.pre = tick ? '0 : st_r.pre + 1'b1;
		end
		if (st_r.running && tick) begin
			if (st_r.count <= 16'h0001) begin
				st_nxt.count = '0;
				st_nxt.running = 1'b0;
				st_nxt.wake = 1'b1;
				st_nxt.stat = 1'b1;
			end else begin
				st_nxt.count = st_r.count - 1'b1;
			end
		end
		// Sleep enable deliberately not used here
		if (wr) begin
			case (wb_adr_i)
				OFF_RELOAD: begin
					if (wb_sel_i[0]) st_nxt.reload[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) st_nxt.reload[15:8] = wb_dat_i[15:8];
					if (wb_sel_i[1:0] != 2'b00) begin
						st_nxt.pre = '0;
						st_nxt.wake = 1'b0;
						if (st_nxt.reload != '0) begin
							st_nxt.count = st_nxt.reload;
							st_nxt.running = 1'b1;
						end else begin
							st_nxt.count = '0;
							st_nxt.running = 1'b0;
						end
					end
				end
				OFF_CTRL: begin
					if (wb_sel_i[0]) st_nxt.coarse = wb_dat_i[CTRL_RES_BIT];
				end
				OFF_IRQ_STAT: begin
					// Hardware set wins over a same-cycle clear
					if (wb_sel_i[0] && wb_dat_i[IRQ_ZERO_BIT] && !st_nxt.wake) begin
						st_nxt.stat = 1'b0;
					end
				end
				OFF_IRQ_MASK: begin
					if (wb_sel_i[0]) st_nxt.mask = wb_dat_i[IRQ_ZERO_BIT];
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
		st_nxt.rdata = '0;
		if (acc && !wb_we_i) begin
			case (wb_adr_i)
				OFF_RELOAD: st_nxt.rdata = {16'h0000, st_r.reload};
				OFF_CTRL: st_nxt.rdata = {31'h0000_0000, st_r.coarse};
				OFF_COUNT: st_nxt.rdata = {16'h0000, st_r.count};
				OFF_IRQ_STAT: st_nxt.rdata = {31'h0000_0000, st_r.stat};
				OFF_IRQ_MASK: st_nxt.rdata = {31'h0000_0000, st_r.mask};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_r <= '0;
			st_r.reload <= RELOAD_RST;
		end else if (clk_en_i) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign hibernation_wake_event_o = st_r.wake;
	assign irq_o = st_r.stat && st_r.mask;
	// Bus clock needed only while a cycle is in flight
	assign bus_clk_req_o = (wb_cyc_i && wb_stb_i) || st_r.ack;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_last_tick;
		st_r.running && tick && st_r.count == 16'h0001 && clk_en_i && !wr;
	endsequence

	sequence s_bus_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
	endsequence

	sequence s_reload_nonzero;
		wr_reload && clk_en_i && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] != 16'h0000;
	endsequence

	sequence s_reload_zero;
		wr_reload && clk_en_i && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == 16'h0000;
	endsequence

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	a_zero_wake_pulse: assert property (
		s_last_tick |=> hibernation_wake_event_o && st_r.count == '0)
		else $error("no wake pulse at zero");

	a_wake_needs_run: assert property (
		hibernation_wake_event_o |-> $past(st_r.running))
		else $error("wake without running timer");

	a_count_step: assert property (
		st_r.running && tick && clk_en_i && !wr && st_r.count > 16'h0001
		|=> st_r.count == $past(st_r.count) - 16'h0001)
		else $error("count did not step by one");

	a_count_hold: assert property (
		st_r.running && !tick && clk_en_i && !wr |=> $stable(st_r.count))
		else $error("count moved without tick");

	a_run_nonzero: assert property (
		st_r.running |-> st_r.count != 16'h0000)
		else $error("running with zero count");

	a_zero_holds: assert property (
		!st_r.running && !wr |=> !st_r.running && $stable(st_r.count))
		else $error("idle count changed");

	a_sleep_ignored: assert property (
		sleep_en_i && st_r.running && !tick && !wr && clk_en_i
		|=> st_r.running)
		else $error("sleep stopped counting");

	a_freeze_hold: assert property (
		!clk_en_i |=> $stable(st_r))
		else $error("state moved while frozen");

	// ----------------------------------------
	// Reload and prescaler
	// ----------------------------------------
	a_reload_load: assert property (
		s_reload_nonzero
		|=> st_r.running && st_r.count == $past(wb_dat_i[15:0]))
		else $error("reload not loaded");

	a_pre_restart: assert property (
		s_reload_nonzero |=> st_r.pre == '0)
		else $error("prescaler not restarted");

	a_zero_disable: assert property (
		s_reload_zero
		|=> !st_r.running ##1 !hibernation_wake_event_o)
		else $error("zero reload did not disable");

	a_pre_idle: assert property (
		!st_r.running && !wr_reload |=> $stable(st_r.pre))
		else $error("prescaler moved while idle");

	a_res_select: assert property (
		st_r.running && clk_en_i && !wr
		|=> st_r.pre <= (st_r.coarse ? PRE_W'(COARSE_CYC - 1) : PRE_W'(FINE_CYC - 1)))
		else $error("prescaler beyond limit");

	a_fine_tick: assert property (
		st_r.running && !st_r.coarse && clk_en_i && !wr && st_r.pre == PRE_W'(FINE_CYC - 1)
		|=> st_r.pre == '0)
		else $error("fine tick period wrong");

	a_coarse_tick: assert property (
		st_r.running && st_r.coarse && clk_en_i && !wr && st_r.pre == PRE_W'(COARSE_CYC - 1)
		|=> st_r.pre == '0)
		else $error("coarse tick period wrong");

	a_ctrl_write: assert property (
		wr_ctrl && clk_en_i |=> st_r.coarse == $past(wb_dat_i[CTRL_RES_BIT]))
		else $error("resolution bit not written");

	// ----------------------------------------
	// Wake event and interrupt
	// ----------------------------------------
	a_wake_single: assert property (
		hibernation_wake_event_o && clk_en_i |=> !hibernation_wake_event_o)
		else $error("wake pulse too long");

	a_wake_at_zero: assert property (
		hibernation_wake_event_o |-> st_r.count == 16'h0000 && !st_r.running)
		else $error("wake with count left");

	a_wake_sets_stat: assert property (
		hibernation_wake_event_o |-> st_r.stat)
		else $error("wake without status");

	a_irq_on_wake: assert property (
		hibernation_wake_event_o && st_r.mask |-> irq_o)
		else $error("unmasked wake gave no interrupt");

	a_irq_gated: assert property (
		!st_r.mask |-> !irq_o)
		else $error("masked interrupt raised");

	a_stat_sticky: assert property (
		st_r.stat && !wr_stat |=> st_r.stat)
		else $error("status lost without clear");

	a_stat_clear: assert property (
		wr_stat && wb_dat_i[IRQ_ZERO_BIT] && clk_en_i && !tick |=> !st_r.stat)
		else $error("status not cleared");

	a_mask_write: assert property (
		wr_mask && clk_en_i |=> st_r.mask == $past(wb_dat_i[IRQ_ZERO_BIT]))
		else $error("mask not written");

	// ----------------------------------------
	// Bus and clock request
	// ----------------------------------------
	a_ack_answer: assert property (
		s_bus_request |=> wb_ack_o)
		else $error("access not acknowledged");

	a_ack_single: assert property (
		wb_ack_o && clk_en_i |=> !wb_ack_o)
		else $error("ack held too long");

	a_rdata_quiet: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	a_read_ack: assert property (
		rd_acc && clk_en_i |=> wb_ack_o)
		else $error("read not acknowledged");

	a_clk_req_access: assert property (
		wb_cyc_i && wb_stb_i |-> bus_clk_req_o)
		else $error("no clock request during access");

	a_clk_req_short: assert property (
		bus_clk_req_o && !wb_cyc_i |-> wb_ack_o)
		else $error("clock request outlived access");

	a_clk_req_idle: assert property (
		!wb_cyc_i && !st_r.ack |-> !bus_clk_req_o)
		else $error("clock requested while idle");

	// ----------------------------------------
	// Reset
	// ----------------------------------------
	// Own disable so the check still sees the reset cycle
	a_reset_clear: assert property (@(posedge sys_clk_i) disable iff (1'b0)
		!resetn_i |=> !st_r.running && !irq_o && !st_r.mask)
		else $error("reset did not clear");

	a_reset_values: assert property (@(posedge sys_clk_i) disable iff (1'b0)
		!resetn_i |=> st_r.reload == RELOAD_RST && !st_r.coarse && !wb_ack_o
		&& !hibernation_wake_event_o && st_r.count == 16'h0000)
		else $error("reset values wrong");
endmodule : hibernation_wake_timer
`default_nettype wire

// File: logic/wake_timer_pkg.sv
// Constants for the hibernation wake timer
package wake_timer_pkg;
	// ----------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------
	localparam logic [4:0] OFF_RELOAD = 5'h00;
	localparam logic [4:0] OFF_CTRL = 5'h04;
	localparam logic [4:0] OFF_COUNT = 5'h08;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
	localparam int ADDR_W = 5;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int CNT_W = 16;
	localparam int CTRL_RES_BIT = 0;
	localparam int IRQ_ZERO_BIT = 0;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int FINE_TICK_PS = 30_517_578;
	localparam int FINE_TICK_CYC = int'((64'(FINE_TICK_PS) * 64'(CLK_HZ)) / 64'd1_000_000_000_000);
	localparam int COARSE_TICK_MS = 125;
	localparam int COARSE_TICK_CYC = int'((64'(COARSE_TICK_MS) * 64'(CLK_HZ)) / 64'd1000);
	localparam int PRE_W = 24;
endpackage : wake_timer_pkg

// File: tb/wake_sink.sv
// Interrupt aggregator model that counts wake pulses
`timescale 1ns/1ps
`default_nettype none
module wake_sink (
	// Clock and event
	input wire logic sys_clk_i,
	input wire logic wake_i,
	// Pulse count
	output var int hits_o
);
	initial hits_o = 0;
	// One count per single-cycle pulse; a stuck level counts every cycle
	always @(posedge sys_clk_i) begin
		if (wake_i === 1'b1) hits_o <= hits_o + 1;
	end
endmodule : wake_sink
`default_nettype wire

// File: tb/hibernation_wake_timer_bench.sv
// Self-checking bench for the hibernation wake timer
`timescale 1ns/1ps
`default_nettype none
module hibernation_wake_timer_bench;
	import wake_timer_pkg::*;
	localparam int FC = 4;
	localparam int CC = 8;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp = 0;
	logic [ADDR_W-1:0] adr = '0;
	logic [31:0] wdat = '0, rdat, dout;
	logic ack, creq, wake, irq;
	int hits, exp_hits = 0, bad_count = 0, checked = 0;
	hibernation_wake_timer #(.FINE_CYC(FC), .COARSE_CYC(CC)) dut (.sys_clk_i(clk),
		.resetn_i(rst_n), .clk_en_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
		.sleep_en_i(slp), .bus_clk_req_o(creq), .hibernation_wake_event_o(wake), .irq_o(irq));
	wake_sink sink (.sys_clk_i(clk), .wake_i(wake), .hits_o(hits));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until ack is seen at a rising edge, then one idle cycle
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk iff ack === 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd
	// No pulse before n-1 steps, exactly one by n+1 steps
	task automatic run(input int n, input int t);
		bus(1'b1, OFF_RELOAD, 32'(n));
		repeat ((n - 1) * t - 1) @(posedge clk);
		chk(32'(hits), 32'(exp_hits));
		repeat (2 * t + 4) @(posedge clk);
		exp_hits++;
		chk(32'(hits), 32'(exp_hits));
	endtask : run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'(creq), 32'h0);
		rd(OFF_RELOAD, 32'h0);
		rd(OFF_CTRL, 32'h0);
		rd(OFF_COUNT, 32'h0);
		rd(OFF_IRQ_STAT, 32'h0);
		rd(OFF_IRQ_MASK, 32'h0);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_W'(2), 32'hFFFF);
		rd(ADDR_W'(2), 32'h0);
		slp <= 1'b1;
		run(3, FC);
		rd(OFF_COUNT, 32'h0);
		rd(OFF_IRQ_STAT, 32'h1);
		chk(32'(irq), 32'h0);
		bus(1'b1, OFF_IRQ_MASK, 32'h1);
		rd(OFF_IRQ_MASK, 32'h1);
		chk(32'(irq), 32'h1);
		bus(1'b1, OFF_IRQ_STAT, 32'h1);
		rd(OFF_IRQ_STAT, 32'h0);
		chk(32'(irq), 32'h0);
		repeat (4 * FC) @(posedge clk);
		chk(32'(hits), 32'(exp_hits));
		bus(1'b1, OFF_RELOAD, 32'h3);
		repeat (2 * FC) @(posedge clk);
		run(3, FC);
		bus(1'b1, OFF_RELOAD, 32'h3);
		repeat (FC) @(posedge clk);
		bus(1'b1, OFF_RELOAD, 32'h0);
		repeat (5 * FC) @(posedge clk);
		chk(32'(hits), 32'(exp_hits));
		bus(1'b1, OFF_CTRL, 32'h1);
		rd(OFF_CTRL, 32'h1);
		run(3, CC);
		chk(32'(creq), 32'h0);
		bus(1'b1, OFF_RELOAD, 32'h3);
		repeat (CC) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFF_CTRL, 32'h0);
		rd(OFF_COUNT, 32'h0);
		rd(OFF_IRQ_MASK, 32'h0);
		repeat (4 * CC) @(posedge clk);
		chk(32'(hits), 32'(exp_hits));
		chk(32'(irq), 32'h0);
		stop_test();
	end
endmodule : hibernation_wake_timer_bench
`default_nettype wire
